// ===== fam_ctrl_model.sv
// Model of the fieldbus controller: reads the status word and acknowledges faults.
// Assumes the manager's clock and reset; the bench calls pulse_ack at a falling edge.
`default_nettype none
module fam_ctrl_model
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] status_word,
  output var logic ack,
  output var logic fault_seen,
  output var logic alarm_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ack = 1'b0;
  // Status bits as the controller samples them
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_seen <= 1'b0;
      alarm_seen <= 1'b0;
    end
    else
    begin
      fault_seen <= status_word[3];
      alarm_seen <= status_word[7];
    end
  end
  // One-cycle acknowledge
  task automatic pulse_ack();
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
  endtask : pulse_ack
endmodule : fam_ctrl_model
`default_nettype wire

// ===== fam_pkg.sv
// Package for the fault and alarm message manager: constants, classes, records.
// Assumes one system clock of 250 MHz and a single design that imports it.
`default_nettype none
package fam_pkg;
  localparam int NSRC = 8;
  localparam int BUF_DEPTH = 8;
  localparam int IDX_W = 3;
  localparam int ZSW_FAULT_BIT = 3;
  localparam int ZSW_ALARM_BIT = 7;
  localparam logic [7:0] PREFIX_FAULT = 8'h46;
  localparam logic [7:0] PREFIX_ALARM = 8'h41;
  localparam logic [7:0] PREFIX_NONE = 8'h00;
  localparam int CLK_KHZ = 250000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;

  // Message class numbers
  typedef enum logic [4:0] {
    MC_NONE = 5'h00,
    MC_HW_SW = 5'h01, // RQ15
    MC_LINE = 5'h02,
    MC_SUPPLY = 5'h03,
    MC_DC_OVERVOLT = 5'h04,
    MC_POWER_ELEC = 5'h05,
    MC_ELEC_OVERTEMP = 5'h06,
    MC_GROUND_SHORT = 5'h07,
    MC_MOTOR_OVERLOAD = 5'h08,
    MC_CTRL_COMM = 5'h09,
    MC_SAFETY_MON = 5'h0A,
    MC_POS_SPEED = 5'h0B, // RQ16
    MC_INT_COMM = 5'h0C,
    MC_INFEED = 5'h0D,
    MC_BRAKING = 5'h0E,
    MC_LINE_FILTER = 5'h0F,
    MC_EXT_SIGNAL = 5'h10,
    MC_APP_LIMIT = 5'h11,
    MC_PARAM_ERR = 5'h12,
    MC_GENERAL = 5'h13,
    MC_AUX_UNIT = 5'h14
  } msg_class_t;

  typedef enum logic [1:0] {RX_NONE, RX_OFF1, RX_OFF2, RX_OFF3} reaction_t;

  typedef struct packed {
    logic is_fault;
    logic [15:0] number;
    logic [7:0] component;
    msg_class_t mclass;
    logic [15:0] diag;
    reaction_t reaction;
  } msg_info_t;

  typedef struct packed {
    logic [7:0] prefix;
    logic [15:0] number;
    logic [7:0] component;
    msg_class_t mclass;
    logic [15:0] diag;
  } msg_rec_t;
endpackage : fam_pkg
`default_nettype wire

// ===== fault_alarm_message_manager.sv
// Fault and alarm message manager: latches, logs and reports drive messages.
// Assumes cause levels and message descriptors synchronous to CLK, steady kinds.
`default_nettype none

// Summary of operation
// [RQ1] Fault records carry prefix F, alarm records prefix A, then the number.
// [RQ2] A raised fault drives its configured reaction code.
// [RQ3] Faults stay latched until acknowledged with their cause gone.
// [RQ4] Status word bit 3 is set while any fault is active.
// [RQ5] Each raised fault is written as a new fault buffer entry.
// [RQ6] Ready lamp flashes red and report shows any active message.
// [RQ7] Alarms never cause a reaction.
// [RQ8] Alarms clear by themselves when their cause goes away.
// [RQ9] Status word bit 7 is set while any alarm is active.
// [RQ10] Each raised alarm is written to a separate alarm buffer.
// [RQ11] An armed trigger fires when a chosen message number is logged.
// [RQ12] Every record holds the detecting component number.
// [RQ13] Every record holds the message diagnostic field.
// [RQ14] Every record holds its message class number.
// [RQ15] Classes 1 to 10 are the first ten profile classes.
// [RQ16] Classes 11 to 20 are the second ten profile classes.
// [RQ17] Report shows faults first, alarms only when no fault remains.
// [RQ18] The other party acknowledges faults with the reset input; the code takes the acknowledge on ACK, not on ARST_N.
// [RQ19] Status bits clear only when no fault or alarm remains; the code clears bit 3 once no fault remains and bit 7 once no alarm remains.
module fault_alarm_message_manager
  import fam_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYC
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [NSRC-1:0] CAUSE,
  input wire msg_info_t [NSRC-1:0] MSG_INFO,
  input wire logic ACK,
  input wire logic TRIG_ARM,
  input wire logic [15:0] TRIG_NUMBER,
  input wire logic BUF_SEL_FAULT,
  input wire logic [IDX_W-1:0] BUF_INDEX,
  output msg_rec_t BUF_DATA,
  output logic [IDX_W:0] FAULT_ENTRIES,
  output logic [IDX_W:0] ALARM_ENTRIES,
  output logic [15:0] DRIVE_STATUS_WORD_ONE,
  output logic READY_LAMP_RED,
  output reaction_t REACTION,
  output msg_rec_t REPORT,
  output logic REPORT_VALID,
  output logic TRIGGER_OUT
);
  logic [NSRC-1:0] cause_prev_reg;
  logic [NSRC-1:0] active_reg;
  logic [NSRC-1:0] pend_reg;
  logic [NSRC-1:0] fault_mask;
  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] grant;
  logic [IDX_W:0] sel;
  logic [IDX_W:0] rep_f;
  logic [IDX_W:0] rep_a;
  logic any_fault;
  logic any_alarm;
  logic any_active;
  msg_rec_t fault_buf [BUF_DEPTH];
  msg_rec_t alarm_buf [BUF_DEPTH];
  logic [IDX_W-1:0] fault_wr_reg;
  logic [IDX_W-1:0] alarm_wr_reg;
  logic [31:0] flash_cnt_reg;
  logic flash_phase_reg;

  // Lowest set bit, with a found flag on top
  function automatic logic [IDX_W:0] first_set(input logic [NSRC-1:0] v);
    logic [IDX_W:0] r;
    r = '0;
    for (int k = NSRC - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        r = {1'b1, IDX_W'(k)};
      end
    end
    return r;
  endfunction : first_set

  function automatic msg_rec_t make_rec(input msg_info_t m);
    msg_rec_t r;
    r.prefix = m.is_fault ? PREFIX_FAULT : PREFIX_ALARM; // RQ1
    r.number = m.number;
    r.component = m.component; // RQ12
    r.mclass = m.mclass; // RQ14 RQ15 RQ16
    r.diag = m.diag; // RQ13
    return r;
  endfunction : make_rec

  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      assign fault_mask[g] = MSG_INFO[g].is_fault;
      assign grant[g] = sel[IDX_W] && (sel[IDX_W-1:0] == IDX_W'(g));
    end
  endgenerate

  assign rise = CAUSE & ~cause_prev_reg;
  assign sel = first_set(pend_reg);
  assign rep_f = first_set(active_reg & fault_mask);
  assign rep_a = first_set(active_reg & ~fault_mask);
  assign any_fault = rep_f[IDX_W];
  assign any_alarm = rep_a[IDX_W];
  assign any_active = any_fault || any_alarm;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      cause_prev_reg <= '0;
    else
      cause_prev_reg <= CAUSE;
  end

  // Fault latching and alarm tracking
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      active_reg <= '0;
    else
    begin
      for (int i = 0; i < NSRC; i++)
      begin
        if (fault_mask[i])
          active_reg[i] <= rise[i] || (active_reg[i] && !(ACK && !CAUSE[i])); // RQ3 RQ18
        else
          active_reg[i] <= CAUSE[i]; // RQ8
      end
    end
  end

  // New raise waits here until logged; a raise beats the grant
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pend_reg <= '0;
    else
      pend_reg <= (pend_reg & ~grant) | rise;
  end

  // Fault buffer
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fault_wr_reg <= '0;
      FAULT_ENTRIES <= '0;
      for (int i = 0; i < BUF_DEPTH; i++)
        fault_buf[i] <= '0;
    end
    else if (sel[IDX_W] && fault_mask[sel[IDX_W-1:0]])
    begin
      fault_buf[fault_wr_reg] <= make_rec(MSG_INFO[sel[IDX_W-1:0]]); // RQ5
      fault_wr_reg <= fault_wr_reg + 1'b1;
      if (FAULT_ENTRIES != (IDX_W+1)'(BUF_DEPTH))
        FAULT_ENTRIES <= FAULT_ENTRIES + 1'b1;
    end
  end

  // Alarm buffer
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      alarm_wr_reg <= '0;
      ALARM_ENTRIES <= '0;
      for (int i = 0; i < BUF_DEPTH; i++)
        alarm_buf[i] <= '0;
    end
    else if (sel[IDX_W] && !fault_mask[sel[IDX_W-1:0]])
    begin
      alarm_buf[alarm_wr_reg] <= make_rec(MSG_INFO[sel[IDX_W-1:0]]); // RQ10
      alarm_wr_reg <= alarm_wr_reg + 1'b1;
      if (ALARM_ENTRIES != (IDX_W+1)'(BUF_DEPTH))
        ALARM_ENTRIES <= ALARM_ENTRIES + 1'b1;
    end
  end

  // Buffer read, index 0 is the newest entry
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      BUF_DATA <= '0;
    else if (BUF_SEL_FAULT)
      BUF_DATA <= fault_buf[fault_wr_reg - BUF_INDEX - 1'b1];
    else
      BUF_DATA <= alarm_buf[alarm_wr_reg - BUF_INDEX - 1'b1];
  end

  // Capture trigger on a logged message number
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      TRIGGER_OUT <= 1'b0;
    else
      TRIGGER_OUT <= TRIG_ARM && sel[IDX_W]
        && (MSG_INFO[sel[IDX_W-1:0]].number == TRIG_NUMBER); // RQ11
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      DRIVE_STATUS_WORD_ONE <= '0;
    else
    begin
      DRIVE_STATUS_WORD_ONE <= '0;
      DRIVE_STATUS_WORD_ONE[ZSW_FAULT_BIT] <= any_fault; // RQ4 RQ19
      DRIVE_STATUS_WORD_ONE[ZSW_ALARM_BIT] <= any_alarm; // RQ9 RQ19
    end
  end

  // Reaction of the lowest-numbered latched fault; alarms take no part
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      REACTION <= RX_NONE;
    else if (any_fault)
      REACTION <= MSG_INFO[rep_f[IDX_W-1:0]].reaction; // RQ2
    else
      REACTION <= RX_NONE; // RQ7
  end

  // Displayed message, faults ahead of alarms
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      REPORT <= '0;
      REPORT_VALID <= 1'b0;
    end
    else
    begin
      REPORT_VALID <= any_active; // RQ6
      if (any_fault)
        REPORT <= make_rec(MSG_INFO[rep_f[IDX_W-1:0]]); // RQ17
      else if (any_alarm)
        REPORT <= make_rec(MSG_INFO[rep_a[IDX_W-1:0]]); // RQ17
      else
        REPORT <= '0;
    end
  end

  // Slow flash divider for the lamp
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      flash_cnt_reg <= '0;
      flash_phase_reg <= 1'b1;
    end
    else if (!any_active)
    begin
      flash_cnt_reg <= '0;
      flash_phase_reg <= 1'b1;
    end
    else if (flash_cnt_reg >= 32'(FLASH_HALF - 1))
    begin
      flash_cnt_reg <= '0;
      flash_phase_reg <= !flash_phase_reg;
    end
    else
      flash_cnt_reg <= flash_cnt_reg + 1'b1;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      READY_LAMP_RED <= 1'b0;
    else
      READY_LAMP_RED <= any_active && flash_phase_reg; // RQ6
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_fault_hold;
    !ACK |=> ((($past(active_reg) & fault_mask) & ~active_reg) == '0);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without ack"); // RQ3

  property p_fault_ack;
    ACK |=> (($past(active_reg) & fault_mask & ~$past(CAUSE) & active_reg) == '0);
  endproperty
  a_fault_ack: assert property (p_fault_ack) else $error("acked fault still latched"); // RQ18

  property p_zsw_fault;
    ((rise & fault_mask) != '0) |-> ##2 DRIVE_STATUS_WORD_ONE[ZSW_FAULT_BIT];
  endproperty
  a_zsw_fault: assert property (p_zsw_fault) else $error("fault bit not set"); // RQ4

  property p_zsw_alarm;
    ((CAUSE & ~fault_mask) != '0) |-> ##2 DRIVE_STATUS_WORD_ONE[ZSW_ALARM_BIT];
  endproperty
  a_zsw_alarm: assert property (p_zsw_alarm) else $error("alarm bit not set"); // RQ9

  property p_alarm_clear;
    ((CAUSE & ~fault_mask) == '0) [*2] |=> !DRIVE_STATUS_WORD_ONE[ZSW_ALARM_BIT];
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm bit stuck"); // RQ8

  property p_no_alarm_reaction;
    !any_fault |=> (REACTION == RX_NONE);
  endproperty
  a_no_alarm_reaction: assert property (p_no_alarm_reaction) else $error("reaction w/o fault"); // RQ7

  property p_log_fault;
    (sel[IDX_W] && fault_mask[sel[IDX_W-1:0]])
      |=> (fault_wr_reg == IDX_W'($past(fault_wr_reg) + 1'b1));
  endproperty
  a_log_fault: assert property (p_log_fault) else $error("fault not logged"); // RQ5

  property p_log_alarm;
    (sel[IDX_W] && !fault_mask[sel[IDX_W-1:0]])
      |=> (alarm_wr_reg == IDX_W'($past(alarm_wr_reg) + 1'b1)) && $stable(fault_wr_reg);
  endproperty
  a_log_alarm: assert property (p_log_alarm) else $error("alarm not logged apart"); // RQ10

  property p_fault_first;
    any_fault |=> REPORT_VALID && (REPORT.prefix == PREFIX_FAULT);
  endproperty
  a_fault_first: assert property (p_fault_first) else $error("alarm shown over fault"); // RQ17

  property p_trigger_armed;
    TRIGGER_OUT |-> $past(TRIG_ARM);
  endproperty
  a_trigger_armed: assert property (p_trigger_armed) else $error("trigger while disarmed"); // RQ11

  property p_lamp_off;
    !any_active |=> !READY_LAMP_RED;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp lit while idle"); // RQ6

  c_fault_acked: cover property (any_fault ##1 ACK ##1 !any_fault);
  c_alarm_self_clear: cover property (any_alarm && !any_fault ##[1:20] !any_alarm);
  c_trigger: cover property (TRIGGER_OUT);
  c_both_active: cover property (any_fault && any_alarm);
endmodule : fault_alarm_message_manager
`default_nettype wire

// ===== fault_alarm_message_manager_tb_top.sv
// Self-checking bench for the fault and alarm message manager.
// Assumes fam_pkg, the manager and fam_ctrl_model are compiled first.
`default_nettype none
module fault_alarm_message_manager_tb_top
  import fam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, ARST_N, TRIG_ARM, BUF_SEL_FAULT, ACK, READY_LAMP_RED, REPORT_VALID, TRIGGER_OUT;
  logic [NSRC-1:0] CAUSE;
  msg_info_t [NSRC-1:0] MSG_INFO;
  logic [15:0] TRIG_NUMBER, DRIVE_STATUS_WORD_ONE;
  logic [IDX_W-1:0] BUF_INDEX;
  logic [IDX_W:0] FAULT_ENTRIES, ALARM_ENTRIES;
  msg_rec_t BUF_DATA, REPORT;
  reaction_t REACTION;
  logic fault_seen, alarm_seen;
  int n_fail = 0;
  int n_checks = 0;
  int trig_cnt = 0;
  int t0;

  fault_alarm_message_manager #(.FLASH_HALF(4)) i_dut (.CLK(CLK), .ARST_N(ARST_N),
    .CAUSE(CAUSE), .MSG_INFO(MSG_INFO), .ACK(ACK), .TRIG_ARM(TRIG_ARM),
    .TRIG_NUMBER(TRIG_NUMBER), .BUF_SEL_FAULT(BUF_SEL_FAULT), .BUF_INDEX(BUF_INDEX),
    .BUF_DATA(BUF_DATA), .FAULT_ENTRIES(FAULT_ENTRIES), .ALARM_ENTRIES(ALARM_ENTRIES),
    .DRIVE_STATUS_WORD_ONE(DRIVE_STATUS_WORD_ONE), .READY_LAMP_RED(READY_LAMP_RED),
    .REACTION(REACTION), .REPORT(REPORT), .REPORT_VALID(REPORT_VALID),
    .TRIGGER_OUT(TRIGGER_OUT));
  fam_ctrl_model i_ctrl (.clk(CLK), .arst_n(ARST_N), .status_word(DRIVE_STATUS_WORD_ONE),
    .ack(ACK), .fault_seen(fault_seen), .alarm_seen(alarm_seen));

  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) if (TRIGGER_OUT === 1'b1) trig_cnt++;

  function automatic msg_rec_t exp_rec(input int i);
    msg_rec_t r;
    r.prefix = MSG_INFO[i].is_fault ? PREFIX_FAULT : PREFIX_ALARM;
    r.number = MSG_INFO[i].number;
    r.component = MSG_INFO[i].component;
    r.mclass = MSG_INFO[i].mclass;
    r.diag = MSG_INFO[i].diag;
    return r;
  endfunction : exp_rec

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_rec(input string what, input msg_rec_t exp, input msg_rec_t got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_rec

  task automatic set_cause(input int i, input logic v);
    CAUSE[i] = v;
    repeat (4) @(negedge CLK);
  endtask : set_cause

  task automatic ack_wait();
    i_ctrl.pulse_ack();
    repeat (3) @(negedge CLK);
  endtask : ack_wait

  task automatic chk_buf(input logic sel, input int idx, input msg_rec_t exp);
    BUF_SEL_FAULT = sel;
    BUF_INDEX = IDX_W'(idx);
    repeat (2) @(negedge CLK);
    chk_rec("buffer", exp, BUF_DATA);
  endtask : chk_buf

  task automatic t_reset();
    chk_val("status", 16'h0000, DRIVE_STATUS_WORD_ONE);
    chk_val("valid", 16'h0000, 16'(REPORT_VALID));
    chk_val("lamp", 16'h0000, 16'(READY_LAMP_RED));
    chk_val("fentries", 16'h0000, 16'(FAULT_ENTRIES));
  endtask : t_reset

  task automatic t_fault();
    set_cause(2, 1'b1);
    chk_val("status", 16'h0008, DRIVE_STATUS_WORD_ONE);
    chk_val("lamp", 16'h0001, 16'(READY_LAMP_RED));
    chk_rec("report", exp_rec(2), REPORT);
    chk_val("reaction", 16'(RX_OFF2), 16'(REACTION));
    chk_val("valid", 16'h0001, 16'(REPORT_VALID));
    chk_val("fentries", 16'h0001, 16'(FAULT_ENTRIES));
    chk_val("seen", 16'h0001, 16'(fault_seen));
    chk_buf(1'b1, 0, exp_rec(2));
    ack_wait();
    chk_val("status", 16'h0008, DRIVE_STATUS_WORD_ONE);
    set_cause(2, 1'b0);
    chk_val("status", 16'h0008, DRIVE_STATUS_WORD_ONE);
    ack_wait();
    chk_val("status", 16'h0000, DRIVE_STATUS_WORD_ONE);
    chk_val("valid", 16'h0000, 16'(REPORT_VALID));
    chk_val("reaction", 16'(RX_NONE), 16'(REACTION));
  endtask : t_fault

  task automatic t_both();
    CAUSE = CAUSE | 8'h23;
    repeat (6) @(negedge CLK);
    chk_val("status", 16'h0088, DRIVE_STATUS_WORD_ONE);
    chk_rec("report", exp_rec(0), REPORT);
    chk_val("fentries", 16'h0003, 16'(FAULT_ENTRIES));
    chk_val("aentries", 16'h0001, 16'(ALARM_ENTRIES));
    chk_buf(1'b1, 0, exp_rec(1));
    chk_buf(1'b1, 1, exp_rec(0));
    chk_buf(1'b0, 0, exp_rec(5));
    CAUSE = CAUSE & 8'hFC;
    ack_wait();
    chk_val("status", 16'h0080, DRIVE_STATUS_WORD_ONE);
    chk_rec("report", exp_rec(5), REPORT);
    chk_val("reaction", 16'(RX_NONE), 16'(REACTION));
    chk_val("seen", 16'h0001, 16'(alarm_seen));
    set_cause(5, 1'b0);
    chk_val("status", 16'h0000, DRIVE_STATUS_WORD_ONE);
    chk_val("valid", 16'h0000, 16'(REPORT_VALID));
  endtask : t_both

  task automatic t_trig();
    TRIG_NUMBER = MSG_INFO[6].number;
    TRIG_ARM = 1'b1;
    t0 = trig_cnt;
    set_cause(6, 1'b1);
    chk_val("trigger", 16'h0001, 16'(trig_cnt - t0));
    set_cause(6, 1'b0);
    set_cause(5, 1'b1);
    chk_val("trigger", 16'h0001, 16'(trig_cnt - t0));
    set_cause(5, 1'b0);
    TRIG_ARM = 1'b0;
    set_cause(6, 1'b1);
    chk_val("trigger", 16'h0001, 16'(trig_cnt - t0));
    set_cause(6, 1'b0);
  endtask : t_trig

  task automatic t_classes();
    for (int k = 1; k <= 20; k++)
    begin
      MSG_INFO[7].mclass = msg_class_t'(5'(k));
      set_cause(7, 1'b1);
      chk_val("class", 16'(k), 16'(REPORT.mclass));
      set_cause(7, 1'b0);
    end
    chk_val("aentries", 16'h0008, 16'(ALARM_ENTRIES));
  endtask : t_classes

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    finish_test();
  end

  initial
  begin
    ARST_N = 1'b0;
    CAUSE = '0;
    TRIG_ARM = 1'b0;
    TRIG_NUMBER = 16'h0000;
    BUF_SEL_FAULT = 1'b0;
    BUF_INDEX = '0;
    for (int i = 0; i < NSRC; i++)
    begin
      MSG_INFO[i].is_fault = (i < 4);
      MSG_INFO[i].number = 16'h1000 + 16'(i);
      MSG_INFO[i].component = 8'(i + 1);
      MSG_INFO[i].mclass = msg_class_t'(5'(i + 1));
      MSG_INFO[i].diag = 16'hD000 + 16'(i);
      MSG_INFO[i].reaction = reaction_t'(2'(i));
    end
    repeat (20) @(negedge CLK);
    ARST_N = 1'b1;
    repeat (2) @(negedge CLK);
    t_reset();
    t_fault();
    t_both();
    t_trig();
    t_classes();
    finish_test();
  end
endmodule : fault_alarm_message_manager_tb_top
`default_nettype wire
